// ### common/adcsr_params.svh
// constants for the converter status and result readout block
// assumes a 32-bit axi4-lite bus with byte addresses in the low 8 bits
//
// Summary of operation
// - The sequence done flag is set when a sequence ends in single mode, and only after the first sequence in continuous mode.
// - Writing the control register starts a fresh sequence and clears the sequence done flag.
// - A three-bit pointer shows the result slot that will be written next, in four- and eight-slot sequences.
// - Eight slot done bits, bit n for slot n, are set when that slot's conversion finishes.
// - A slot done bit stays set until its slot is read, and the read clears it unless that slot's conversion finishes in the same cycle.
// - Every stored result is readable at three addresses, and the address picks the format.
// - Unsigned right view puts a 10-bit result in bits 9..0, an 8-bit one in 7..0 with 9..8 zero.
// - Unsigned right view always reads zero in bits 15..10.
// - Signed left view puts a 10-bit result in bits 15..6, an 8-bit one in 15..8 with 7..6 zero.
// - Signed view takes mid-reference as zero, so bit 15 is 0 above it and 1 below it.
// - Unsigned left view puts a 10-bit result in bits 15..6, an 8-bit one in 15..8 with 7..6 zero.
// - Both left views always read zero in bits 5..0.
// - A sequence is four or eight conversions, as the eight conversion select says.
// - With scanning off one sequence runs and stops; with it on, sequences repeat.
`ifndef ADCSR_PARAMS_SVH
`define ADCSR_PARAMS_SVH

// register byte offsets
`define ADCSR_OFS_CTRL 8'h00
`define ADCSR_OFS_STAT 8'h04
`define ADCSR_OFS_INT 8'h08
`define ADCSR_OFS_MASK 8'h0C
`define ADCSR_OFS_UR 8'h40
`define ADCSR_OFS_SL 8'h60
`define ADCSR_OFS_UL 8'h80
`define ADCSR_OFS_END 8'hA0

// control fields
`define ADCSR_CTL_SCAN 0
`define ADCSR_CTL_EIGHT 1
`define ADCSR_CTL_RES10 2

// interrupt status and mask fields
`define ADCSR_INT_SEQ 0
`define ADCSR_INT_SLOT 1

// reset values and last slot numbers
`define ADCSR_RST_CTRL 3'h0
`define ADCSR_RST_MASK 2'h0
`define ADCSR_LAST4 3'h3
`define ADCSR_LAST8 3'h7

// bus answers
`define ADCSR_RESP_OKAY 2'h0
`define ADCSR_RESP_SLVERR 2'h2

`endif

// ### common/adcsr_pkg.sv
// types for the converter status and result readout block
// assumes adcsr_params.svh for all numeric constants
package adcsr_pkg;
    typedef enum logic [1:0] {
        ADCSR_ST_IDLE = 2'b01,
        ADCSR_ST_RUN = 2'b10
    } adcsr_state_type;

    typedef enum logic [1:0] {
        ADCSR_VIEW_UR = 2'h0,
        ADCSR_VIEW_SL = 2'h1,
        ADCSR_VIEW_UL = 2'h2
    } adcsr_view_type;
endpackage

// ### common/adcsr_fmt_if.sv
// carrier between the register file and the result formatter
// assumes adcsr_pkg is compiled first
`timescale 1ns/1ps
interface adcsr_fmt_if;
    logic [9:0] raw;
    logic res10;
    adcsr_pkg::adcsr_view_type view;
    logic [15:0] word;

    modport src (output raw, output res10, output view, input word);
    modport fmt (input raw, input res10, input view, output word);
endinterface

// ### logic/adcsr_format.sv
// result formatter: one stored result into one of three read views
// assumes raw holds an 8-bit result in its low bits when res10 is low
`timescale 1ns/1ps
module adcsr_format (
    adcsr_fmt_if.fmt f
);
    // pick the layout from the view code
    always_comb begin
        unique case (f.view)
            adcsr_pkg::ADCSR_VIEW_UR: begin
                if (f.res10) begin
                    f.word = {6'h00, f.raw};
                end else begin
                    f.word = {8'h00, f.raw[7:0]};
                end
            end
            adcsr_pkg::ADCSR_VIEW_SL: begin
                // midpoint is zero: flip the top bit
                if (f.res10) begin
                    f.word = {~f.raw[9], f.raw[8:0], 6'h00};
                end else begin
                    f.word = {~f.raw[7], f.raw[6:0], 8'h00};
                end
            end
            adcsr_pkg::ADCSR_VIEW_UL: begin
                if (f.res10) begin
                    f.word = {f.raw, 6'h00};
                end else begin
                    f.word = {f.raw[7:0], 8'h00};
                end
            end
            default: begin
                f.word = 16'h0000;
            end
        endcase
    end
endmodule

// ### logic/adcsr_top.sv
// converter status and result readout with an axi4-lite register slave
// assumes the converter core runs on clk_sys and pulses conv_valid
//
// Design decisions made here: the AXI4-Lite slave port and the address map.
`timescale 1ns/1ps
`include "adcsr_params.svh"
module adcsr_top (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic conv_valid,
    input wire logic [9:0] conv_result,
    output logic conv_busy,
    output logic [2:0] conv_slot,
    output logic irq
);
    ////////////////////////////////////////////////////////////////////////
    // state
    logic aw_held, w_held;
    logic [7:0] aw_addr;
    logic [15:0] w_data;
    logic [1:0] w_strb;
    logic next_awready, next_wready, next_aw_held, next_w_held;
    logic [7:0] next_aw_addr;
    logic [15:0] next_w_data;
    logic [1:0] next_w_strb;
    logic next_bvalid, next_arready, next_rvalid;
    logic [1:0] next_bresp, next_rresp;
    logic [31:0] next_rdata;

    logic [2:0] ctrl, next_ctrl;
    logic [1:0] int_mask, next_int_mask;
    logic [1:0] int_stat, next_int_stat;
    adcsr_pkg::adcsr_state_type state, next_state;
    logic [2:0] ptr, next_ptr;
    logic first_seq, next_first_seq;
    logic seq_done, next_seq_done;
    logic [7:0] slot_bits, next_slot_bits;
    logic [9:0] slots [8];
    logic [9:0] next_slots [8];
    logic next_irq, next_conv_busy;

    // decode helpers
    logic wr_fire, wr_mapped, ctl_start, mask_wr, int_wr;
    logic rd_take, rd_mapped, is_result, is_ur, is_sl, is_left;
    logic [7:0] rd_ofs, rd_clr;
    logic [2:0] last_slot;
    logic conv_accept, seq_end;
    logic [15:0] stat_word;

    adcsr_fmt_if fmt_bus ();

    adcsr_format u_format (
        .f (fmt_bus)
    );

    ////////////////////////////////////////////////////////////////////////
    // address decode
    assign wr_fire = aw_held && w_held && !s_axi_bvalid;
    assign wr_mapped = aw_addr < `ADCSR_OFS_END && aw_addr[1:0] == 2'h0
        && (aw_addr <= `ADCSR_OFS_MASK || aw_addr >= `ADCSR_OFS_UR);
    assign ctl_start = wr_fire && aw_addr == `ADCSR_OFS_CTRL && w_strb[0];
    assign mask_wr = wr_fire && aw_addr == `ADCSR_OFS_MASK && w_strb[0];
    assign int_wr = wr_fire && aw_addr == `ADCSR_OFS_INT && w_strb[0];

    assign rd_ofs = s_axi_araddr[7:0];
    assign rd_take = s_axi_arvalid && s_axi_arready;
    assign rd_mapped = rd_ofs < `ADCSR_OFS_END && rd_ofs[1:0] == 2'h0
        && (rd_ofs <= `ADCSR_OFS_MASK || rd_ofs >= `ADCSR_OFS_UR);
    assign is_result = rd_take && rd_mapped && rd_ofs >= `ADCSR_OFS_UR;
    assign is_ur = is_result && rd_ofs < `ADCSR_OFS_SL;
    assign is_sl = is_result && rd_ofs >= `ADCSR_OFS_SL
        && rd_ofs < `ADCSR_OFS_UL;
    assign is_left = is_result && rd_ofs >= `ADCSR_OFS_SL;
    // a result read clears that slot's done bit
    assign rd_clr = is_result ? (8'h01 << rd_ofs[4:2]) : 8'h00;

    // sequence length and end
    assign last_slot = ctrl[`ADCSR_CTL_EIGHT] ? `ADCSR_LAST8
        : `ADCSR_LAST4;
    assign conv_accept = conv_valid && state == adcsr_pkg::ADCSR_ST_RUN;
    assign seq_end = conv_accept && ptr == last_slot;
    assign stat_word = {seq_done, 4'h0, ptr, slot_bits};

    // formatter feed: slot picked by address, view by address range
    assign fmt_bus.raw = slots[rd_ofs[4:2]];
    assign fmt_bus.res10 = ctrl[`ADCSR_CTL_RES10];
    assign fmt_bus.view = is_ur ? adcsr_pkg::ADCSR_VIEW_UR
        : is_sl ? adcsr_pkg::ADCSR_VIEW_SL
        : adcsr_pkg::ADCSR_VIEW_UL;

    ////////////////////////////////////////////////////////////////////////
    // bus group next values
    always_comb begin
        next_aw_held = aw_held;
        next_aw_addr = aw_addr;
        next_w_held = w_held;
        next_w_data = w_data;
        next_w_strb = w_strb;
        next_bvalid = s_axi_bvalid;
        next_bresp = s_axi_bresp;
        next_arready = s_axi_arready;
        next_rvalid = s_axi_rvalid;
        next_rresp = s_axi_rresp;
        next_rdata = s_axi_rdata;
        if (s_axi_awvalid && s_axi_awready) begin
            next_aw_held = 1'b1;
            next_aw_addr = s_axi_awaddr[7:0];
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_w_held = 1'b1;
            next_w_data = s_axi_wdata[15:0];
            next_w_strb = s_axi_wstrb[1:0];
        end
        if (s_axi_bvalid && s_axi_bready) begin
            next_bvalid = 1'b0;
        end
        // write executes once address and data are both in
        if (wr_fire) begin
            next_aw_held = 1'b0;
            next_w_held = 1'b0;
            next_bvalid = 1'b1;
            next_bresp = wr_mapped ? `ADCSR_RESP_OKAY : `ADCSR_RESP_SLVERR;
        end
        next_awready = !next_aw_held;
        next_wready = !next_w_held;
        if (s_axi_rvalid && s_axi_rready) begin
            next_rvalid = 1'b0;
            next_arready = 1'b1;
        end
        if (rd_take) begin
            next_rvalid = 1'b1;
            next_arready = 1'b0;
            next_rresp = rd_mapped ? `ADCSR_RESP_OKAY : `ADCSR_RESP_SLVERR;
            next_rdata = 32'h0000_0000;
            if (is_result) begin
                next_rdata = {16'h0000, fmt_bus.word};
            end else if (rd_ofs == `ADCSR_OFS_CTRL) begin
                next_rdata = {29'h0000_0000, ctrl};
            end else if (rd_ofs == `ADCSR_OFS_STAT) begin
                next_rdata = {16'h0000, stat_word};
            end else if (rd_ofs == `ADCSR_OFS_INT) begin
                next_rdata = {30'h0000_0000, int_stat};
            end else if (rd_ofs == `ADCSR_OFS_MASK) begin
                next_rdata = {30'h0000_0000, int_mask};
            end
        end
    end

    // bus group registers
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            aw_held <= 1'b0;
            aw_addr <= 8'h00;
            w_held <= 1'b0;
            w_data <= 16'h0000;
            w_strb <= 2'h0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `ADCSR_RESP_OKAY;
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rresp <= `ADCSR_RESP_OKAY;
            s_axi_rdata <= 32'h0000_0000;
        end else begin
            aw_held <= next_aw_held;
            aw_addr <= next_aw_addr;
            w_held <= next_w_held;
            w_data <= next_w_data;
            w_strb <= next_w_strb;
            s_axi_awready <= next_awready;
            s_axi_wready <= next_wready;
            s_axi_bvalid <= next_bvalid;
            s_axi_bresp <= next_bresp;
            s_axi_arready <= next_arready;
            s_axi_rvalid <= next_rvalid;
            s_axi_rresp <= next_rresp;
            s_axi_rdata <= next_rdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // converter group next values
    always_comb begin
        next_ctrl = ctrl;
        next_int_mask = int_mask;
        next_int_stat = int_stat;
        next_state = state;
        next_ptr = ptr;
        next_first_seq = first_seq;
        next_seq_done = seq_done;
        next_slots = slots;
        // result reads clear done bits, a same-cycle set below wins
        next_slot_bits = slot_bits & ~rd_clr;
        if (mask_wr) begin
            next_int_mask = w_data[1:0];
        end
        if (int_wr) begin
            next_int_stat = int_stat & ~w_data[1:0];
        end
        // control write restarts at slot zero
        if (ctl_start) begin
            next_ctrl = w_data[2:0];
            next_state = adcsr_pkg::ADCSR_ST_RUN;
            next_ptr = 3'h0;
            next_first_seq = 1'b1;
            next_seq_done = 1'b0;
        end else if (conv_accept) begin
            next_slots[ptr] = ctrl[`ADCSR_CTL_RES10] ? conv_result
                : {2'h0, conv_result[7:0]};
            next_slot_bits[ptr] = 1'b1;
            next_int_stat[`ADCSR_INT_SLOT] = 1'b1;
            if (seq_end) begin
                next_ptr = 3'h0;
                next_first_seq = 1'b0;
                if (first_seq) begin
                    next_seq_done = 1'b1;
                    next_int_stat[`ADCSR_INT_SEQ] = 1'b1;
                end
                if (!ctrl[`ADCSR_CTL_SCAN]) begin
                    next_state = adcsr_pkg::ADCSR_ST_IDLE;
                end
            end else begin
                next_ptr = ptr + 3'h1;
            end
        end
        next_irq = |(next_int_stat & next_int_mask);
        next_conv_busy = next_state == adcsr_pkg::ADCSR_ST_RUN;
    end

    // converter group registers
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            ctrl <= `ADCSR_RST_CTRL;
            int_mask <= `ADCSR_RST_MASK;
            int_stat <= 2'h0;
            state <= adcsr_pkg::ADCSR_ST_IDLE;
            ptr <= 3'h0;
            first_seq <= 1'b0;
            seq_done <= 1'b0;
            slot_bits <= 8'h00;
            for (int i = 0; i < 8; i++) begin
                slots[i] <= 10'h000;
            end
            irq <= 1'b0;
            conv_busy <= 1'b0;
            conv_slot <= 3'h0;
        end else begin
            ctrl <= next_ctrl;
            int_mask <= next_int_mask;
            int_stat <= next_int_stat;
            state <= next_state;
            ptr <= next_ptr;
            first_seq <= next_first_seq;
            seq_done <= next_seq_done;
            slot_bits <= next_slot_bits;
            slots <= next_slots;
            irq <= next_irq;
            conv_busy <= next_conv_busy;
            conv_slot <= next_ptr;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    seq_set_a: assert property (
        seq_end && first_seq && !ctl_start |=> seq_done)
        else $error("sequence done flag not set at first end");
    seq_keep_a: assert property (
        $rose(seq_done) |-> $past(seq_end && first_seq && !ctl_start))
        else $error("sequence done flag set outside a first sequence end");
    seq_clr_a: assert property (
        ctl_start |=> !seq_done && ptr == 3'h0 ##1 1'b1)
        else $error("control write did not restart the sequence");
    ptr_step_a: assert property (
        conv_accept && !seq_end && !ctl_start |=> ptr == $past(ptr) + 3'h1)
        else $error("slot pointer did not advance");
    slot_set_a: assert property (
        conv_accept && !ctl_start |=> slot_bits[$past(ptr)])
        else $error("slot done bit not set");
    slot_clr_a: assert property (
        is_result && !conv_accept |=> (slot_bits & $past(rd_clr)) == 8'h00)
        else $error("slot done bit survived its read");
    ur_zero_a: assert property (
        $rose(s_axi_rvalid) && $past(is_ur) |-> s_axi_rdata[31:10] == 22'h0)
        else $error("right view has bits above 9");
    left_low_a: assert property (
        $rose(s_axi_rvalid) && $past(is_left) |-> s_axi_rdata[5:0] == 6'h00)
        else $error("left view has low bits set");
    four_len_a: assert property (
        conv_accept && !ctrl[`ADCSR_CTL_EIGHT] && ptr == `ADCSR_LAST4
        && !ctl_start
        |=> ptr == 3'h0)
        else $error("four-slot sequence did not wrap");
    single_stop_a: assert property (
        seq_end && !ctrl[`ADCSR_CTL_SCAN] && !ctl_start
        |=> state == adcsr_pkg::ADCSR_ST_IDLE
        ##1 (state == adcsr_pkg::ADCSR_ST_IDLE || $past(ctl_start)))
        else $error("single sequence did not stop");
    irq_level_a: assert property (
        irq == |(int_stat & int_mask))
        else $error("interrupt level differs from unmasked events");

    seq_cov: cover property (seq_end && ctrl[`ADCSR_CTL_EIGHT]);
    scan_cov: cover property (seq_end && !first_seq);
    read_cov: cover property (is_sl ##1 s_axi_rvalid);
    race_cov: cover property (conv_accept && rd_clr[ptr]);
endmodule

// ### bench/adc_status_result_readout_test.sv
// self-checking bench for the converter status and result readout block
// assumes adcsr_top with an axi4-lite slave, register map in adcsr_params.svh
`timescale 1ns/1ps
`include "adcsr_params.svh"
module adc_status_result_readout_test;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, irq, conv_busy;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    logic conv_valid = 1'b0;
    logic [9:0] conv_result = '0;
    logic [2:0] conv_slot;
    int n_errors = 0;
    int checks_done = 0;
    int cycles = 0;
    logic [33:0] exp_r[$];
    logic [1:0] exp_b[$];
    logic [31:0] rng = 32'h0000_7858;
    logic [9:0] res[8];
    logic res10 = 1'b0;

    ////////////////////////////////////////////////////////////////////////
    // clock, design instance
    always #20 clk_sys = ~clk_sys;

    adcsr_top i_adcsr_top (.clk_sys(clk_sys), .rst(rst),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .conv_valid(conv_valid),
        .conv_result(conv_result), .conv_busy(conv_busy),
        .conv_slot(conv_slot), .irq(irq));

    ////////////////////////////////////////////////////////////////////////
    // helpers: comparison, random source, expected read views
    task automatic chk(input logic [33:0] got, input logic [33:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    function automatic logic [31:0] xs(input logic [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    // view 0 unsigned right, 1 signed left, 2 unsigned left
    function automatic logic [31:0] fmt(input int v, input logic [9:0] r);
        logic [9:0] u;
        u = res10 ? r : {r[7:0], 2'b00};
        if (v == 0)
            return res10 ? {22'h0, r} : {24'h00_0000, r[7:0]};
        if (v == 1)
            return {16'h0000, ~u[9], u[8:0], 6'h00};
        return {16'h0000, u, 6'h00};
    endfunction

    function automatic logic [31:0] stat(input logic seq, input logic [2:0] p,
                                          input logic [7:0] d);
        return {16'h0000, seq, 4'h0, p, d};
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // bus tasks: note the expectation, run the handshake
    task automatic wr(input logic [31:0] a, input logic [31:0] d,
                      input logic [1:0] resp);
        logic aw_done, w_done;
        aw_done = 1'b0;
        w_done = 1'b0;
        exp_b.push_back(resp);
        @(posedge clk_sys);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!(aw_done && w_done)) begin
            @(posedge clk_sys);
            if (!aw_done && s_axi_awready) begin
                aw_done = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (!w_done && s_axi_wready) begin
                w_done = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end
        do @(posedge clk_sys); while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
    endtask

    task automatic rd(input logic [31:0] a, input logic [33:0] exp);
        exp_r.push_back(exp);
        @(posedge clk_sys);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge clk_sys); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        do @(posedge clk_sys); while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
    endtask

    // one converter result pulse, then the pointer it leaves behind
    task automatic conv(input logic [2:0] next_ptr);
        @(posedge clk_sys);
        rng = xs(rng);
        conv_result <= rng[9:0];
        res[conv_slot] = res10 ? rng[9:0] : {2'b00, rng[7:0]};
        conv_valid <= 1'b1;
        @(posedge clk_sys);
        conv_valid <= 1'b0;
        @(posedge clk_sys);
        chk({31'h0, conv_slot}, {31'h0, next_ptr});
    endtask

    ////////////////////////////////////////////////////////////////////////
    // watcher: each answer takes the oldest note off its queue
    always @(posedge clk_sys) begin
        if (s_axi_rvalid && s_axi_rready)
            chk({s_axi_rresp, s_axi_rdata},
                exp_r.size() ? exp_r.pop_front() : 34'h3_FFFF_FFFF);
        if (s_axi_bvalid && s_axi_bready)
            chk({32'h0000_0000, s_axi_bresp},
                exp_b.size() ? {32'h0, exp_b.pop_front()} : 34'h3);
    end

    // hang limit
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 6000) begin
            n_errors++;
            $display("Error at %0t: run did not complete", $time);
            finish_test();
        end
    end

    task automatic finish_test();
        $display("checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        logic [33:0] ok;
        ok = '0;
        repeat (4) @(posedge clk_sys);
        rst <= 1'b0;
        rd(`ADCSR_OFS_STAT, ok);
        rd(`ADCSR_OFS_MASK, ok);
        // single four-slot sequence at 10 bits
        res10 = 1'b1;
        wr(`ADCSR_OFS_CTRL, 32'h1 << `ADCSR_CTL_RES10, `ADCSR_RESP_OKAY);
        chk({33'h0, conv_busy}, 34'h1);
        for (int i = 0; i < 4; i++)
            conv(3'(i + 1) & `ADCSR_LAST4);
        chk({33'h0, conv_busy}, 34'h0);
        rd(`ADCSR_OFS_STAT, {2'h0, stat(1, 0, 8'h0F)});
        rd(`ADCSR_OFS_INT, 34'h3);
        chk({33'h0, irq}, 34'h0);
        wr(`ADCSR_OFS_MASK, 32'h3, `ADCSR_RESP_OKAY);
        repeat (2) @(posedge clk_sys);
        chk({33'h0, irq}, 34'h1);
        wr(`ADCSR_OFS_INT, 32'h3, `ADCSR_RESP_OKAY);
        repeat (2) @(posedge clk_sys);
        chk({33'h0, irq}, 34'h0);
        // three views of each slot, done bit cleared by the first read
        for (int n = 0; n < 4; n++) begin
            rd(`ADCSR_OFS_UR + 4 * n, {2'h0, fmt(0, res[n])});
            rd(`ADCSR_OFS_SL + 4 * n, {2'h0, fmt(1, res[n])});
            rd(`ADCSR_OFS_UL + 4 * n, {2'h0, fmt(2, res[n])});
            rd(`ADCSR_OFS_STAT, {2'h0, stat(1, 0,
                8'h0F & ~((8'h2 << n) - 8'h1))});
        end
        // writes to read-only places, unmapped and unaligned access
        wr(`ADCSR_OFS_STAT, 32'hFFFF, `ADCSR_RESP_OKAY);
        wr(`ADCSR_OFS_UR, 32'hFFFF, `ADCSR_RESP_OKAY);
        rd(`ADCSR_OFS_UR, {2'h0, fmt(0, res[0])});
        rd(`ADCSR_OFS_STAT, {2'h0, stat(1, 0, 8'h00)});
        wr(`ADCSR_OFS_END, 32'h1, `ADCSR_RESP_SLVERR);
        rd(`ADCSR_OFS_END, {`ADCSR_RESP_SLVERR, 32'h0});
        rd(`ADCSR_OFS_UR + 2, {`ADCSR_RESP_SLVERR, 32'h0});
        // continuous eight-slot scanning at 8 bits
        res10 = 1'b0;
        wr(`ADCSR_OFS_CTRL, 32'h3, `ADCSR_RESP_OKAY);
        for (int i = 0; i < 7; i++)
            conv(3'(i + 1));
        rd(`ADCSR_OFS_STAT, {2'h0, stat(0, 7, 8'h7F)});
        conv(3'h0);
        rd(`ADCSR_OFS_STAT, {2'h0, stat(1, 0, 8'hFF)});
        chk({33'h0, conv_busy}, 34'h1);
        for (int i = 0; i < 8; i++)
            conv(3'(i + 1) & `ADCSR_LAST8);
        rd(`ADCSR_OFS_UR + 28, {2'h0, fmt(0, res[7])});
        rd(`ADCSR_OFS_SL + 28, {2'h0, fmt(1, res[7])});
        rd(`ADCSR_OFS_UL + 28, {2'h0, fmt(2, res[7])});
        // restart clears the sequence flag, not the slot bits
        wr(`ADCSR_OFS_CTRL, 32'h0, `ADCSR_RESP_OKAY);
        rd(`ADCSR_OFS_STAT, {2'h0, stat(0, 0, 8'h7F)});
        chk({33'h0, conv_busy}, 34'h1);
        repeat (2) @(posedge clk_sys);
        finish_test();
    end
endmodule
